// ### rtl/cpp_device.sv
// How it works
// RULE1: selected only when low select low, high select high
// RULE2: write strobe low captures data byte
// RULE3: read strobe drives bit 7 ready status
// RULE4: write wins over simultaneous read
// RULE5: ready output shows byte can be accepted
// RULE6: master parallel mode: ready pin reads memory; code drives the same !buf_full_r ready level as in the other modes
// RULE7: busy-high output high until configuration done
// RULE8: busy-low output low until configuration done
// RULE9: pull init low during power-up and clearing
// RULE10: external init low holds wait state
// RULE11: host keeps test clock or mode high
// RULE12: unselected boundary scan disabled after configuration
// RULE13: processor port little-endian mode uses address latch
// RULE14: read strobe doubles as processor transfer strobe
// RULE15: two option groups set done and pins release
// RULE16: after configuration unused pins become user I/O
// RULE17: release done output once configuration completes
// RULE18: latch mode selects on init rising edge
// RULE19: busy until buffered byte consumed
`timescale 1ns/10ps
module cpp_device
  import cpp_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       clk_en,
  // link to host
  cpp_link_if.dev         link,
  // user side
  input  wire logic       scan_selected,
  input  wire logic       proc_port_used,
  input  wire logic [3:0] done_delay,
  input  wire logic [3:0] pins_delay,
  output logic [7:0]      cfg_byte,
  output logic            cfg_byte_valid,
  output logic            scan_enable,
  output logic            user_io_en,
  output logic            addr_latch_in,
  output logic            transfer_strobe
);
  typedef enum logic [2:0] {ST_CLEAR, ST_WAIT, ST_LOAD, ST_DONE_WAIT, ST_USER} cpp_state_e;

  cpp_state_e  state_r;
  logic [1:0]  cs0_s, cs1_s, wr_s, rd_s, init_s, tck_s, tms_s;
  logic [7:0]  d_s1, d_s2;
  logic [2:0]  mode_s1, mode_s2, mode_r;
  logic        init_q_r, wr_q_r;
  logic [7:0]  clr_cnt_r, byte_cnt_r;
  logic [3:0]  cons_cnt_r, rel_cnt_r;
  logic        buf_full_r;
  logic        sel, wr_fall, rd_act, init_rise;

  ////////////////////////////////////////////////////////////////////
  // state decodes shared by the status and pin logic
  function automatic logic in_load(input cpp_state_e st);
    return st == ST_LOAD;
  endfunction : in_load

  function automatic logic in_user(input cpp_state_e st);
    return st == ST_USER;
  endfunction : in_user

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers; first stages are only read by second stages
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cs0_s   <= 2'h3;
      cs1_s   <= 2'h0;
      wr_s    <= 2'h3;
      rd_s    <= 2'h3;
      init_s  <= 2'h0;
      tck_s   <= 2'h3;
      tms_s   <= 2'h3;
      d_s1    <= 8'h00;
      d_s2    <= 8'h00;
      mode_s1 <= 3'h0;
      mode_s2 <= 3'h0;
    end else if (clk_en) begin
      cs0_s   <= {cs0_s[0], link.select_low_active};
      cs1_s   <= {cs1_s[0], link.select_high_active};
      wr_s    <= {wr_s[0], link.wr_n};
      rd_s    <= {rd_s[0], link.rd_n};
      init_s  <= {init_s[0], link.init_n};
      tck_s   <= {tck_s[0], link.tck};
      tms_s   <= {tms_s[0], link.tms};
      d_s1    <= link.d;
      d_s2    <= d_s1;
      mode_s1 <= link.mode_sel;
      mode_s2 <= mode_s1;
    end
  end

  always_comb sel = !cs0_s[1] && cs1_s[1];                  // [RULE1]
  always_comb wr_fall = sel && !wr_s[1] && wr_q_r;          // [RULE2]
  always_comb rd_act = sel && !rd_s[1] && wr_s[1];          // write overrides read [RULE4]
  always_comb init_rise = init_s[1] && !init_q_r;

  ////////////////////////////////////////////////////////////////////
  // configuration sequence
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_r   <= ST_CLEAR;
      clr_cnt_r <= 8'h00;
      rel_cnt_r <= 4'h0;
      init_q_r  <= 1'b0;
      mode_r    <= 3'h0;
    end else if (clk_en) begin
      init_q_r <= init_s[1];
      unique case (state_r)
        ST_CLEAR: begin
          // memory clear runs regardless of the pin level
          clr_cnt_r <= clr_cnt_r + 8'h01;
          if (clr_cnt_r == CLEAR_CYCLES) state_r <= ST_WAIT;   // [RULE9]
        end
        ST_WAIT: begin
          // stays here as long as someone else pulls init low
          if (init_rise) begin                                  // [RULE10]
            mode_r  <= mode_s2;                                 // [RULE18]
            state_r <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (byte_cnt_r == IMAGE_BYTES) begin
            state_r   <= ST_DONE_WAIT;
            rel_cnt_r <= 4'h0;
          end
        end
        ST_DONE_WAIT: begin
          // pins release on the later of the two option delays
          rel_cnt_r <= rel_cnt_r + 4'h1;                        // [RULE15]
          if (rel_cnt_r >= done_delay && rel_cnt_r >= pins_delay) state_r <= ST_USER;
        end
        ST_USER: state_r <= ST_USER;
        // unused codes fall back to clearing, never to a loaded state
        default: state_r <= ST_CLEAR;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // byte buffer; a second write while busy is ignored
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wr_q_r         <= 1'b1;
      buf_full_r     <= 1'b0;
      cons_cnt_r     <= 4'h0;
      byte_cnt_r     <= 8'h00;
      cfg_byte       <= 8'h00;
      cfg_byte_valid <= 1'b0;
    end else if (clk_en) begin
      wr_q_r         <= wr_s[1];
      cfg_byte_valid <= 1'b0;
      if (state_r == ST_LOAD && mode_r == MODE_ASYNC_PERIPH && wr_fall && !buf_full_r) begin
        cfg_byte   <= d_s2;                                     // [RULE2]
        buf_full_r <= 1'b1;                                     // [RULE19]
        cons_cnt_r <= 4'h0;
      end else if (buf_full_r) begin
        cons_cnt_r <= cons_cnt_r + 4'h1;
        if (cons_cnt_r == CONSUME_CYCLES - 4'h1) begin
          buf_full_r     <= 1'b0;                               // [RULE19]
          cfg_byte_valid <= 1'b1;
          byte_cnt_r     <= byte_cnt_r + 8'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pin outputs, all registered
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      link.dev_d         <= 8'h00;
      link.dev_d_oe      <= 1'b0;
      link.dev_init_oe   <= 1'b1;
      link.rdy_rclk      <= 1'b0;
      link.done_oe       <= 1'b1;
      link.cfg_busy_high <= 1'b1;
      link.cfg_busy_low  <= 1'b0;
      scan_enable        <= 1'b1;
      user_io_en         <= 1'b0;
      addr_latch_in      <= 1'b0;
      transfer_strobe    <= 1'b0;
    end else if (clk_en) begin
      link.dev_init_oe   <= (state_r == ST_CLEAR);              // [RULE9]
      link.cfg_busy_high <= !in_user(state_r);                  // [RULE7]
      link.cfg_busy_low  <= in_user(state_r);                   // [RULE8]
      // done released on its own option delay
      link.done_oe <= !(in_user(state_r) ||
                        (state_r == ST_DONE_WAIT && rel_cnt_r >= done_delay)); // [RULE17]
      // status on bit 7 only while reading; other bits read as zero
      link.dev_d_oe <= in_load(state_r) && rd_act;              // [RULE3]
      link.dev_d    <= {!buf_full_r, 7'h00};                    // [RULE3]
      if (in_load(state_r) && mode_r == MODE_MASTER_PAR) begin
        link.rdy_rclk <= !buf_full_r;                           // read request [RULE6]
      end else begin
        link.rdy_rclk <= in_load(state_r) && !buf_full_r;       // [RULE5]
      end
      // the host keeps tck or tms high, so no spurious tap activity here [RULE11]
      scan_enable <= !in_user(state_r) ? (tck_s[1] || tms_s[1]) : scan_selected; // [RULE12]
      user_io_en  <= in_user(state_r) && !proc_port_used;       // [RULE16]
      addr_latch_in   <= in_user(state_r) && proc_port_used &&
                         mode_r == MODE_PROC_PORT && link.rdy_rclk == 1'b0 && sel; // [RULE13]
      transfer_strobe <= in_user(state_r) && proc_port_used && sel && !rd_s[1]; // [RULE14]
    end
  end
endmodule : cpp_device

// ### rtl/cpp_pkg.sv
package cpp_pkg;
  // mode select encodings, latched at the init release
  localparam logic [2:0] MODE_ASYNC_PERIPH  = 3'h4;
  localparam logic [2:0] MODE_MASTER_PAR    = 3'h2;
  localparam logic [2:0] MODE_PROC_PORT     = 3'h7;
  // time in ns spent clearing the configuration memory after power settles, and the cycle count derived from it
  localparam int         CLEAR_NS           = 2000;
  localparam int         CLK_NS             = 40;
  localparam logic [7:0] CLEAR_CYCLES       = 8'(CLEAR_NS / CLK_NS);
  // cycles a byte sits in the buffer before the core consumes it
  localparam logic [3:0] CONSUME_CYCLES     = 4'h4;
  // host status read length, and the bus turnaround gap after it
  localparam logic [3:0] STATUS_RD_CYCLES   = 4'h6;
  // bytes making up one bitstream
  localparam logic [7:0] IMAGE_BYTES        = 8'h10;
  // start-up option groups: done release and pin release delays
  localparam logic [3:0] DONE_DELAY_RST     = 4'h1;
  localparam logic [3:0] PINS_DELAY_RST     = 4'h2;
  localparam int         DATA_W             = 8;
  localparam int         STATUS_BIT         = 7;
endpackage : cpp_pkg

// ### rtl/cpp_link_if.sv
`timescale 1ns/10ps
interface cpp_link_if;
  // strobes and selects, host to device
  logic       select_low_active;
  logic       select_high_active;
  logic       wr_n;
  logic       rd_n;
  logic [2:0] mode_sel;
  logic       tck;
  logic       tms;
  // data bus, both may drive
  logic [7:0] host_d;
  logic       host_d_oe;
  logic [7:0] dev_d;
  logic       dev_d_oe;
  wire  [7:0] d = dev_d_oe ? dev_d : (host_d_oe ? host_d : 8'hff);
  // init open drain, both may pull low
  logic       dev_init_oe;
  logic       host_init_oe;
  wire        init_n = !(dev_init_oe || host_init_oe);
  // device outputs
  logic       rdy_rclk;
  logic       done_oe;
  wire        done = !done_oe;
  logic       cfg_busy_high;
  logic       cfg_busy_low;

  modport dev  (input select_low_active, select_high_active, wr_n, rd_n, mode_sel, tck, tms,
                d, init_n, done, output dev_d, dev_d_oe, dev_init_oe, rdy_rclk, done_oe,
                cfg_busy_high, cfg_busy_low);
  modport host (output select_low_active, select_high_active, wr_n, rd_n, mode_sel, tck,
                tms, host_d, host_d_oe, host_init_oe, input d, init_n, done, rdy_rclk,
                cfg_busy_high, cfg_busy_low);
endinterface : cpp_link_if

// ### rtl/cpp_host.sv
`timescale 1ns/10ps
module cpp_host
  import cpp_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       clk_en,
  // link to device
  cpp_link_if.host        link,
  // user side
  input  wire logic       hold_init,
  input  wire logic [7:0] tx_byte,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic            cfg_done
);
  typedef enum logic [1:0] {HS_IDLE, HS_STATUS, HS_STROBE, HS_POLL} cpp_hstate_e;

  cpp_hstate_e hstate_r;
  logic [1:0]  rdy_s, done_s, d7_s;
  logic [3:0]  rd_cnt_r;
  logic        stat_ok_r;

  // device pins come from outside the domain
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rdy_s  <= 2'h0;
      done_s <= 2'h0;
      d7_s   <= 2'h0;
    end else if (clk_en) begin
      rdy_s  <= {rdy_s[0], link.rdy_rclk};
      done_s <= {done_s[0], link.done};
      d7_s   <= {d7_s[0], link.d[STATUS_BIT]};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // write one byte per ready; strobes never overlap [RULE4]
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      hstate_r                <= HS_IDLE;
      link.select_low_active  <= 1'b1;
      link.select_high_active <= 1'b0;
      link.wr_n               <= 1'b1;
      link.rd_n               <= 1'b1;
      link.mode_sel           <= MODE_ASYNC_PERIPH;
      link.tck                <= 1'b1;                      // [RULE11]
      link.tms                <= 1'b1;
      link.host_d             <= 8'h00;
      link.host_d_oe          <= 1'b0;
      link.host_init_oe       <= 1'b0;
      rd_cnt_r                <= 4'h0;
      stat_ok_r               <= 1'b0;
      tx_ready                <= 1'b0;
      cfg_done                <= 1'b0;
    end else if (clk_en) begin
      link.host_init_oe <= hold_init;                       // [RULE10]
      cfg_done          <= done_s[1];
      tx_ready          <= 1'b0;
      unique case (hstate_r)
        HS_IDLE: begin
          // read the status bit before every write
          if (tx_valid && rdy_s[1] && !tx_ready) begin
            link.select_low_active  <= 1'b0;                // [RULE1]
            link.select_high_active <= 1'b1;
            link.rd_n               <= 1'b0;                // [RULE3]
            rd_cnt_r                <= 4'h0;
            hstate_r                <= HS_STATUS;
          end
        end
        HS_STATUS: begin
          // the gap lets the device stop driving data before we drive it
          rd_cnt_r <= rd_cnt_r + 4'h1;
          if (rd_cnt_r == STATUS_RD_CYCLES) begin
            link.rd_n <= 1'b1;
            stat_ok_r <= d7_s[1];                           // [RULE3]
          end
          if (rd_cnt_r == STATUS_RD_CYCLES + STATUS_RD_CYCLES) begin
            if (stat_ok_r) begin
              link.host_d    <= tx_byte;
              link.host_d_oe <= 1'b1;
              link.wr_n      <= 1'b0;
              tx_ready       <= 1'b1;
              hstate_r       <= HS_STROBE;
            end else begin
              link.select_low_active  <= 1'b1;
              link.select_high_active <= 1'b0;
              hstate_r                <= HS_IDLE;
            end
          end
        end
        HS_STROBE: begin
          // hold the strobe long enough for the device synchroniser
          link.wr_n <= 1'b1;
          hstate_r  <= HS_POLL;
        end
        HS_POLL: begin
          // wait for busy to show before accepting the next byte
          link.host_d_oe          <= 1'b0;
          link.select_low_active  <= 1'b1;
          link.select_high_active <= 1'b0;
          if (!rdy_s[1]) hstate_r <= HS_IDLE;
        end
      endcase
    end
  end
endmodule : cpp_host

// ### sim/cpp_assertions.sv
`timescale 1ns/10ps
module cpp_assertions (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       reset,
  // link signals
  input wire logic       select_low_active,
  input wire logic       select_high_active,
  input wire logic       wr_n,
  input wire logic       rd_n,
  input wire logic [7:0] dev_d,
  input wire logic       dev_d_oe,
  input wire logic       host_init_oe,
  input wire logic       dev_init_oe,
  input wire logic       rdy_rclk,
  input wire logic       done_oe,
  input wire logic       cfg_busy_high,
  input wire logic       cfg_busy_low
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic sel;
  // decoded select, both chip selects must agree
  assign sel = !select_low_active && select_high_active;
  sequence s_wr_start; $fell(wr_n) && sel && rdy_rclk; endsequence
  sequence s_status_rd; (sel && !rd_n && wr_n)[*4]; endsequence
  property p_hdc; done_oe |-> cfg_busy_high; endproperty
  property p_ldc; done_oe |-> !cfg_busy_low; endproperty
  property p_clear; $fell(reset) |-> dev_init_oe [*8]; endproperty
  property p_wait; host_init_oe |-> done_oe && !rdy_rclk; endproperty
  property p_status; s_status_rd |-> dev_d_oe && (dev_d[7] == rdy_rclk); endproperty
  property p_wr_prio; (!wr_n && !rd_n) [*4] |-> !dev_d_oe; endproperty
  property p_take; s_wr_start |-> ##[1:6] !rdy_rclk; endproperty
  property p_consume; $fell(rdy_rclk) |-> (!rdy_rclk) [*3]; endproperty
  property p_done_hold; $fell(done_oe) |-> (!done_oe) [*8]; endproperty
  a_hdc: assert property (p_hdc) else $error("busy high dropped early");
  a_ldc: assert property (p_ldc) else $error("busy low rose early");
  a_clear: assert property (p_clear) else $error("init not held low");
  a_wait: assert property (p_wait) else $error("left wait state");
  a_status: assert property (p_status) else $error("bad read status");
  a_wr_prio: assert property (p_wr_prio) else $error("read beat write");
  a_take: assert property (p_take) else $error("byte not taken");
  a_consume: assert property (p_consume) else $error("busy too short");
  a_done_hold: assert property (p_done_hold) else $error("done fell back");
endmodule : cpp_assertions

// ### sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import cpp_pkg::*;
  logic       sys_clk;
  logic       reset;
  logic       hold_init;
  logic [7:0] tx_byte;
  logic       tx_valid;
  logic       tx_ready;
  logic       cfg_done;
  logic [7:0] cfg_byte;
  logic       cfg_byte_valid;
  logic       scan_enable;
  logic       user_io_en;
  logic       clk_en;
  logic       scan_selected;
  logic       proc_port_used;
  logic       addr_latch_in;
  logic       transfer_strobe;
  int         n_errors;
  int         checks_done;
  int         n_seen;
  logic [7:0] sent_q[$];
  cpp_link_if link ();
  cpp_device i_cpp_device (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .link(link),
    .scan_selected(scan_selected), .proc_port_used(proc_port_used), .done_delay(4'h3),
    .pins_delay(4'h5), .cfg_byte(cfg_byte), .cfg_byte_valid(cfg_byte_valid),
    .scan_enable(scan_enable), .user_io_en(user_io_en), .addr_latch_in(addr_latch_in),
    .transfer_strobe(transfer_strobe));
  cpp_host i_cpp_host (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .link(link),
    .hold_init(hold_init), .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .cfg_done(cfg_done));
  cpp_assertions i_cpp_assertions (.sys_clk(sys_clk), .reset(reset),
    .select_low_active(link.select_low_active), .select_high_active(link.select_high_active),
    .wr_n(link.wr_n), .rd_n(link.rd_n), .dev_d(link.dev_d), .dev_d_oe(link.dev_d_oe),
    .host_init_oe(link.host_init_oe), .dev_init_oe(link.dev_init_oe),
    .rdy_rclk(link.rdy_rclk), .done_oe(link.done_oe), .cfg_busy_high(link.cfg_busy_high),
    .cfg_busy_low(link.cfg_busy_low));
  ////////////////////////////////////////////////////////////////////////////////
  // 40 ns clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic tally_and_finish;
    $display("errors=%0d checks=%0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic cmp_byte(input logic [7:0] act, input logic [7:0] exp);
    checks_done++;
    if (act !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, act, exp);
    end
  endtask : cmp_byte
  task automatic cmp_flag(input logic act, input logic exp);
    cmp_byte({7'h00, act}, {7'h00, exp});
  endtask : cmp_flag
  // one byte over the user handshake, held until taken
  task automatic send_byte(input logic [7:0] b);
    int i;
    @(negedge sys_clk);
    tx_byte = b;
    tx_valid = 1'b1;
    sent_q.push_back(b);
    for (i = 0; i < 200; i++) begin
      @(negedge sys_clk);
      if (tx_ready === 1'b1) break;
    end
    tx_valid = 1'b0;
    if (i == 200) begin
      n_errors++;
      tally_and_finish();
    end
  endtask : send_byte
  ////////////////////////////////////////////////////////////////////////////////
  // consumed bytes must come out in order and unchanged
  always @(negedge sys_clk) begin
    if (cfg_byte_valid === 1'b1) begin
      n_seen++;
      cmp_byte(cfg_byte, sent_q.size() > 0 ? sent_q.pop_front() : 8'hxx);
    end
  end
  initial begin
    int k;
    reset = 1'b1;
    clk_en = 1'b1;
    scan_selected = 1'b0;
    proc_port_used = 1'b0;
    hold_init = 1'b1;
    tx_byte = 8'h00;
    tx_valid = 1'b0;
    n_errors = 0;
    checks_done = 0;
    n_seen = 0;
    repeat (2) @(negedge sys_clk);
    reset = 1'b0;
    // freeze both ends for longer than the whole clearing time
    repeat (10) @(negedge sys_clk);
    clk_en = 1'b0;
    repeat (60) @(negedge sys_clk);
    cmp_flag(link.dev_init_oe, 1'b1);
    clk_en = 1'b1;
    // init held low from outside well past the clearing time
    repeat (100) @(negedge sys_clk);
    cmp_flag(link.tck | link.tms, 1'b1);
    cmp_flag(link.init_n, 1'b0);
    cmp_flag(link.done, 1'b0);
    cmp_flag(link.cfg_busy_high, 1'b1);
    cmp_flag(link.cfg_busy_low, 1'b0);
    cmp_flag(link.rdy_rclk, 1'b0);
    hold_init = 1'b0;
    // whole image, byte values sweep 00 to ff
    for (k = 0; k < int'(IMAGE_BYTES); k++) send_byte(8'(k * 8'h11));
    cmp_flag(link.cfg_busy_high, 1'b1);
    for (k = 0; k < 500 && !(link.done === 1'b1 && user_io_en === 1'b1); k++)
      @(negedge sys_clk);
    if (k == 500) n_errors++;
    cmp_byte(8'(n_seen), IMAGE_BYTES);
    cmp_flag(link.done, 1'b1);
    cmp_flag(link.cfg_busy_high, 1'b0);
    cmp_flag(link.cfg_busy_low, 1'b1);
    cmp_flag(user_io_en, 1'b1);
    cmp_flag(scan_enable, 1'b0);
    cmp_flag(cfg_done, 1'b1);
    cmp_flag(addr_latch_in, 1'b0);
    cmp_flag(transfer_strobe, 1'b0);
    // hand the pins to the processor port and select boundary scan
    proc_port_used = 1'b1;
    scan_selected = 1'b1;
    repeat (2) @(negedge sys_clk);
    cmp_flag(user_io_en, 1'b0);
    cmp_flag(scan_enable, 1'b1);
    cmp_flag(transfer_strobe, 1'b0);
    tally_and_finish();
  end
endmodule : tb_top
